// File: cfg_pkg.sv
package cfg_pkg;

   // ***************************************************************
   // register map (byte addresses, one 32-bit word each)
   // ***************************************************************
   localparam logic [7:0] OFS_SAMPLED = 8'h00;
   localparam logic [7:0] OFS_DECODED = 8'h04;
   localparam logic [7:0] OFS_STARTUP = 8'h08;
   localparam logic [7:0] OFS_WDT_CTRL = 8'h0c;
   localparam logic [7:0] OFS_REMAP = 8'h10;
   localparam logic [7:0] OFS_PWM_KEY = 8'h14;

   // field positions
   localparam int WDT_SW_BIT = 0;
   localparam int REMAP_COMMIT_BIT = 0;
   localparam int REMAP_CLR_REFUSED_BIT = 1;
   localparam int REMAP_CNT_LSB = 8;

   // values after reset
   localparam logic RST_SW_WDT = 1'b0;
   localparam logic RST_PROTECT = 1'b1;
   localparam logic RST_WAITREQ = 1'b1;
   localparam logic [7:0] RST_REMAP_CNT = 8'h00;

   // watchdog window as parts per thousand of the period
   localparam logic [9:0] WIN_PM_24 = 10'h0f0;
   localparam logic [9:0] WIN_PM_37_5 = 10'h177;
   localparam logic [9:0] WIN_PM_50 = 10'h1f4;
   localparam logic [9:0] WIN_PM_75 = 10'h2ee;

   // ***************************************************************
   // encodings
   // ***************************************************************
   typedef enum logic [2:0] {
      SEL_FRC = 3'h0,
      SEL_FRCDIV_PLL = 3'h1,
      SEL_PRI = 3'h2,
      SEL_PRI_PLL = 3'h3,
      SEL_SECONDARY_OSCILLATOR = 3'h4,
      SEL_LOW_POWER_INTERNAL_RC = 3'h5,
      SEL_RESERVED = 3'h6,
      SEL_FRCDIV = 3'h7
   } osc_sel_t;

   typedef enum logic [2:0] {
      SRC_FRC = 3'h0,
      SRC_FRCDIV = 3'h1,
      SRC_PRI = 3'h2,
      SRC_SECONDARY_OSCILLATOR = 3'h3,
      SRC_LOW_POWER_INTERNAL_RC = 3'h4
   } clk_src_t;

   typedef enum logic [1:0] {
      PRI_EC = 2'h0,
      PRI_MS = 2'h1,
      PRI_HS = 2'h2,
      PRI_OFF = 2'h3
   } pri_mode_t;

   typedef enum {KEY_IDLE, KEY_GOT_FIRST} key_state_t;

   // stored configuration fields as captured
   typedef struct packed {
      logic codeProt;
      logic writeProt;
      logic twoSpeed;
      logic pwm_key_lock;
      logic [1:0] watchdog_window_select;
      logic [2:0] oscSel;
      logic [1:0] clkSwMode;
      logic pinOneShot;
      logic oscPinFn;
      logic [1:0] primMode;
      logic wdtAlways;
      logic wdtWinDis;
   } cfg_raw_t;

   // decoded static controls
   typedef struct packed {
      logic codeProtect;
      logic writeProtect;
      logic twoSpeed;
      logic pwmKeyRequired;
      logic [9:0] windowPermille;
      logic windowMode;
      logic [2:0] startSrc;
      logic pllEnable;
      logic srcReserved;
      logic primaryEnable;
      logic [1:0] primaryMode;
      logic clkSwitchEn;
      logic failSafeEn;
      logic remapOnce;
      logic oscPinClkOut;
      logic wdtForced;
   } cfg_dec_t;

endpackage

// File: cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
// raw fields in, decoded controls out
interface cfg_if;
   import cfg_pkg::*;
   cfg_raw_t raw;
   cfg_dec_t dec;
   modport decoder (input raw, output dec);
   modport owner (output raw, input dec);
endinterface
`default_nettype wire

// File: config_field_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module config_field_decoder
   import cfg_pkg::*;
(
   cfg_if.decoder bus
);

   cfg_dec_t d;

   // ***************************************************************
   // pure decode of the stored fields
   // ***************************************************************
   always_comb begin
      d = '0;
      d.codeProtect = ~bus.raw.codeProt; // [RULE1]
      d.writeProtect = ~bus.raw.writeProt; // [RULE2]
      d.twoSpeed = bus.raw.twoSpeed; // [RULE3]
      d.pwmKeyRequired = bus.raw.pwm_key_lock; // [RULE4]
      // window share of the watchdog period
      case (bus.raw.watchdog_window_select)
         2'b11: d.windowPermille = WIN_PM_24; // [RULE5]
         2'b10: d.windowPermille = WIN_PM_37_5; // [RULE5]
         2'b01: d.windowPermille = WIN_PM_50; // [RULE5]
         default: d.windowPermille = WIN_PM_75; // [RULE5]
      endcase
      // start-up source; reserved code falls back to fast rc
      case (osc_sel_t'(bus.raw.oscSel))
         SEL_FRCDIV: d.startSrc = SRC_FRCDIV; // [RULE6]
         SEL_LOW_POWER_INTERNAL_RC: d.startSrc = SRC_LOW_POWER_INTERNAL_RC; // [RULE6]
         SEL_SECONDARY_OSCILLATOR: d.startSrc = SRC_SECONDARY_OSCILLATOR; // [RULE6]
         SEL_PRI_PLL: begin
            d.startSrc = SRC_PRI; // [RULE6]
            d.pllEnable = 1'b1;
         end
         SEL_PRI: d.startSrc = SRC_PRI; // [RULE6]
         SEL_FRCDIV_PLL: begin
            d.startSrc = SRC_FRCDIV; // [RULE6]
            d.pllEnable = 1'b1;
         end
         SEL_RESERVED: begin
            d.startSrc = SRC_FRC; // [RULE7]
            d.srcReserved = 1'b1; // [RULE7]
         end
         default: d.startSrc = SRC_FRC; // [RULE6]
      endcase
      // 1x: neither; 01: switch only; 00: both
      d.clkSwitchEn = ~bus.raw.clkSwMode[1]; // [RULE8]
      d.failSafeEn = (bus.raw.clkSwMode == 2'b00); // [RULE8]
      d.remapOnce = bus.raw.pinOneShot; // [RULE9]
      d.primaryMode = bus.raw.primMode; // [RULE11]
      d.primaryEnable = (bus.raw.primMode != PRI_OFF); // [RULE11]
      // crystal modes own the pin, so no clock out there
      d.oscPinClkOut = bus.raw.oscPinFn
         & (bus.raw.primMode != PRI_MS)
         & (bus.raw.primMode != PRI_HS); // [RULE10]
      d.wdtForced = bus.raw.wdtAlways; // [RULE12]
      d.windowMode = ~bus.raw.wdtWinDis; // [RULE13]
      bus.dec = d;
   end

endmodule
`default_nettype wire

// File: config_word_decoder.sv
// Overview of operation
// [RULE1] code-protect 0 guards all program memory readout
// [RULE2] write-protect 0 blocks user program memory writes
// [RULE3] two-speed 1: fast rc first, then selected
// [RULE4] pwm lock 1: writes need key sequence
// [RULE5] window codes give 24, 37.5, 50, 75 percent
// [RULE6] three-bit field picks the start-up oscillator
// [RULE7] programmer never writes reserved oscillator code 110
// [RULE8] clock switch mode: 1x none, 01, 00 both
// [RULE9] one-shot 1 allows a single pin remap
// [RULE10] pin function 1 gives clock out, not crystal
// [RULE11] primary mode: off, high, medium, external clock
// [RULE12] watchdog always-on overrides the software enable
// [RULE13] window-disable 1 means non-window watchdog
// [RULE14] capture fields once at reset, then hold
`timescale 1ns/1ps
`default_nettype none
module config_word_decoder
   import cfg_pkg::*;
#(
   parameter int ADDR_W = 8,
   // key words are arbitrary values
   parameter logic [15:0] PWM_KEY_FIRST = 16'h5a5a,
   parameter logic [15:0] PWM_KEY_SECOND = 16'ha5a5
) (
   input wire logic clk,
   input wire logic arst_n,
   // stored configuration fields
   input wire logic generalCodeProtect,
   input wire logic generalWriteProtect,
   input wire logic twoSpeedStartupEnable,
   input wire logic pwmKeyLock,
   input wire logic [1:0] watchdogWindowSelect,
   input wire logic [2:0] startupOscillatorSelect,
   input wire logic [1:0] clockSwitchMonitorMode,
   input wire logic pinSelectOneShot,
   input wire logic oscPinFunction,
   input wire logic [1:0] primaryOscMode,
   input wire logic watchdogAlwaysOn,
   input wire logic watchdogWindowDisable,
   // status from neighbouring units
   input wire logic oscReady,
   input wire logic pwmRegWrite,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // decoded controls
   output logic configValid,
   output logic codeReadProtect,
   output logic progWriteProtect,
   output logic twoSpeedStartup,
   output logic [2:0] startupSource,
   output logic [2:0] activeSource,
   output logic pllEnable,
   output logic oscSelectReserved,
   output logic primaryOscEnable,
   output logic [1:0] primaryOscModeOut,
   output logic clockSwitchEnable,
   output logic failSafeMonitorEnable,
   output logic pinRemapEnable,
   output logic pwmWriteEnable,
   output logic oscPinClockOut,
   output logic watchdogEnable,
   output logic lowPowerRcEnable,
   output logic watchdogWindowMode,
   output logic [9:0] watchdogWindowPermille
);

   // ***************************************************************
   // parameter checks
   // ***************************************************************
   if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
      $error("ADDR_W must be 5 to 8");
   end

   // ***************************************************************
   // reset release
   // ***************************************************************
   logic rstMeta;
   logic rstSync;

   // two flops so release never lands mid-cycle for the logic
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end

   // ***************************************************************
   // decoder
   // ***************************************************************
   cfg_if cfgBus ();

   config_field_decoder u_decoder (
      .bus(cfgBus.decoder)
   );

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      logic captured;
      cfg_raw_t raw;
      cfg_dec_t dec;
      logic [2:0] active;
      logic onTarget;
      logic swWdt;
      logic [7:0] remapCount;
      logic remapLocked;
      logic remapRefused;
      key_state_t keyState;
      logic pwmUnlocked;
      logic waitreq;
      logic [31:0] rdata;
   } top_t;

   top_t s;
   top_t next_s;

   // merges enabled bytes of a write into an old word
   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
         input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // stored fields feed the decoder only after capture
   assign cfgBus.raw = s.raw;

   logic [7:0] addr8;
   logic [31:0] wrWord;
   logic busTake;
   logic wrTake;
   logic pwmOpen;

   // accepted on the edge where waitrequest is already low
   assign addr8 = 8'(address);
   assign busTake = (read | write) & ~s.waitreq;
   assign wrTake = write & busTake;
   assign wrWord = mergeBytes(32'h0000_0000, writedata, byteenable);
   assign pwmOpen = ~s.dec.pwmKeyRequired | s.pwmUnlocked; // [RULE4]

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      next_s = s;

      // one capture after reset release; held until next reset
      if (!s.captured) begin
         next_s.captured = 1'b1; // [RULE14]
         next_s.raw.codeProt = generalCodeProtect;
         next_s.raw.writeProt = generalWriteProtect;
         next_s.raw.twoSpeed = twoSpeedStartupEnable;
         next_s.raw.pwm_key_lock = pwmKeyLock;
         next_s.raw.watchdog_window_select = watchdogWindowSelect;
         next_s.raw.oscSel = startupOscillatorSelect;
         next_s.raw.clkSwMode = clockSwitchMonitorMode;
         next_s.raw.pinOneShot = pinSelectOneShot;
         next_s.raw.oscPinFn = oscPinFunction;
         next_s.raw.primMode = primaryOscMode;
         next_s.raw.wdtAlways = watchdogAlwaysOn;
         next_s.raw.wdtWinDis = watchdogWindowDisable;
      end

      // decode lands one cycle after capture, then stays frozen
      if (s.captured) begin
         next_s.dec = cfgBus.dec; // [RULE14]
      end

      // with two-speed, start on fast rc and move over once the target is ready
      if (s.captured && !s.onTarget) begin
         if (!cfgBus.dec.twoSpeed || cfgBus.dec.startSrc == SRC_FRC) begin
            next_s.active = cfgBus.dec.startSrc; // [RULE3]
            next_s.onTarget = 1'b1;
         end else if (oscReady) begin
            next_s.active = cfgBus.dec.startSrc; // [RULE3]
            next_s.onTarget = 1'b1;
         end else begin
            next_s.active = SRC_FRC; // [RULE3]
         end
      end

      // the pwm unit spends one unlock per keyed write
      if (pwmRegWrite && s.dec.pwmKeyRequired) begin
         next_s.pwmUnlocked = 1'b0; // [RULE4]
      end

      // bus handshake: one wait cycle, then answer for one cycle
      next_s.waitreq = RST_WAITREQ;
      if ((read | write) && s.waitreq) begin
         next_s.waitreq = 1'b0;
      end

      // read data prepared during the wait cycle
      next_s.rdata = 32'h0000_0000;
      if (read && s.waitreq) begin
         if (addr8 == OFS_SAMPLED) begin
            next_s.rdata = 32'(s.raw);
         end else if (addr8 == OFS_DECODED) begin
            next_s.rdata = 32'(s.dec);
         end else if (addr8 == OFS_STARTUP) begin
            next_s.rdata = {26'h0, s.captured, s.onTarget, 1'b0,
               s.active};
         end else if (addr8 == OFS_WDT_CTRL) begin
            next_s.rdata = {30'h0, s.dec.wdtForced, s.swWdt};
         end else if (addr8 == OFS_REMAP) begin
            next_s.rdata = {16'h0, s.remapCount, 5'h0, s.dec.remapOnce,
               s.remapRefused, s.remapLocked};
         end else if (addr8 == OFS_PWM_KEY) begin
            next_s.rdata = {29'h0, s.dec.pwmKeyRequired, pwmOpen,
               s.pwmUnlocked};
         end else begin
            next_s.rdata = 32'h0000_0000; // unmapped reads zero
         end
      end

      // register writes take effect on the accepting edge
      if (wrTake) begin
         if (addr8 == OFS_WDT_CTRL) begin
            if (byteenable[0]) begin
               // ignored by the outputs while always-on is set
               next_s.swWdt = wrWord[WDT_SW_BIT]; // [RULE12]
            end
         end else if (addr8 == OFS_REMAP) begin
            if (wrWord[REMAP_CLR_REFUSED_BIT]) begin
               next_s.remapRefused = 1'b0;
            end
            if (wrWord[REMAP_COMMIT_BIT]) begin
               if (s.remapLocked) begin
                  next_s.remapRefused = 1'b1; // [RULE9]
               end else begin
                  next_s.remapCount = s.remapCount + 8'h01;
                  // one-shot locks after the first commit
                  next_s.remapLocked = s.dec.remapOnce; // [RULE9]
               end
            end
         end else if (addr8 == OFS_PWM_KEY) begin
            // any wrong word aborts and relocks
            case (s.keyState)
               KEY_IDLE: begin
                  next_s.pwmUnlocked = 1'b0;
                  if (wrWord[15:0] == PWM_KEY_FIRST) begin
                     next_s.keyState = KEY_GOT_FIRST; // [RULE4]
                  end
               end
               default: begin
                  next_s.keyState = KEY_IDLE;
                  next_s.pwmUnlocked =
                     (wrWord[15:0] == PWM_KEY_SECOND); // [RULE4]
               end
            endcase
         end
      end
   end

   // ***************************************************************
   // registers
   // ***************************************************************
   // safe values until capture: protected, software watchdog off
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         s <= '0;
         s.dec.codeProtect <= RST_PROTECT;
         s.dec.writeProtect <= RST_PROTECT;
         s.dec.primaryMode <= PRI_OFF;
         s.swWdt <= RST_SW_WDT;
         s.remapCount <= RST_REMAP_CNT;
         s.keyState <= KEY_IDLE;
         s.waitreq <= RST_WAITREQ;
         s.rdata <= 32'h0000_0000;
      end else begin
         s <= next_s;
      end
   end

   // ***************************************************************
   // outputs, each from the state flops or from the two extra enable flops
   // ***************************************************************
   logic wdtRun;
   logic pwmEn;

   // extra flops keep the combined enables registered
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         wdtRun <= 1'b0;
         pwmEn <= 1'b0;
      end else begin
         wdtRun <= next_s.dec.wdtForced | next_s.swWdt; // [RULE12]
         pwmEn <= ~next_s.dec.pwmKeyRequired
            | next_s.pwmUnlocked; // [RULE4]
      end
   end

   assign readdata = s.rdata;
   assign waitrequest = s.waitreq;
   assign configValid = s.captured;
   assign codeReadProtect = s.dec.codeProtect;
   assign progWriteProtect = s.dec.writeProtect;
   assign twoSpeedStartup = s.dec.twoSpeed;
   assign startupSource = s.dec.startSrc;
   assign activeSource = s.active;
   assign pllEnable = s.dec.pllEnable;
   assign oscSelectReserved = s.dec.srcReserved;
   assign primaryOscEnable = s.dec.primaryEnable;
   assign primaryOscModeOut = s.dec.primaryMode;
   assign clockSwitchEnable = s.dec.clkSwitchEn;
   assign failSafeMonitorEnable = s.dec.failSafeEn;
   assign pinRemapEnable = ~s.remapLocked;
   assign pwmWriteEnable = pwmEn;
   assign oscPinClockOut = s.dec.oscPinClkOut;
   assign watchdogEnable = wdtRun;
   assign lowPowerRcEnable = wdtRun; // watchdog needs its rc running
   assign watchdogWindowMode = s.dec.windowMode;
   assign watchdogWindowPermille = s.dec.windowPermille;

endmodule
`default_nettype wire

// File: config_checker.sv
`timescale 1ns/1ps
`default_nettype none
module config_checker
   import cfg_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic generalCodeProtect,
   input wire logic generalWriteProtect,
   input wire logic twoSpeedStartupEnable,
   input wire logic pwmKeyLock,
   input wire logic [1:0] watchdogWindowSelect,
   input wire logic [2:0] startupOscillatorSelect,
   input wire logic [1:0] clockSwitchMonitorMode,
   input wire logic pinSelectOneShot,
   input wire logic oscPinFunction,
   input wire logic [1:0] primaryOscMode,
   input wire logic watchdogAlwaysOn,
   input wire logic watchdogWindowDisable,
   input wire logic read,
   input wire logic write,
   input wire logic waitrequest,
   input wire logic configValid,
   input wire logic codeReadProtect,
   input wire logic progWriteProtect,
   input wire logic twoSpeedStartup,
   input wire logic [2:0] startupSource,
   input wire logic pllEnable,
   input wire logic oscSelectReserved,
   input wire logic primaryOscEnable,
   input wire logic [1:0] primaryOscModeOut,
   input wire logic clockSwitchEnable,
   input wire logic failSafeMonitorEnable,
   input wire logic pwmWriteEnable,
   input wire logic oscPinClockOut,
   input wire logic watchdogEnable,
   input wire logic lowPowerRcEnable,
   input wire logic watchdogWindowMode,
   input wire logic [9:0] watchdogWindowPermille
);
   // ********
   // copy of the fields
   // ********
   cfg_raw_t r;
   logic [1:0] age;
   logic ok;
   assign ok = (age == 2'h3);
   // copy once; age gives the decoded outputs time to settle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r <= '0;
         age <= 2'h0;
      end else if (configValid && !ok) begin
         age <= age + 2'h1;
         if (age == 2'h0) begin
            r <= {generalCodeProtect, generalWriteProtect,
               twoSpeedStartupEnable, pwmKeyLock, watchdogWindowSelect,
               startupOscillatorSelect, clockSwitchMonitorMode,
               pinSelectOneShot, oscPinFunction, primaryOscMode,
               watchdogAlwaysOn, watchdogWindowDisable};
         end
      end
   end
   // reserved code falls back to the plain fast rc
   function automatic logic [2:0] src_of(input logic [2:0] s);
      case (s)
         3'h7, 3'h1: return SRC_FRCDIV;
         3'h5: return SRC_LOW_POWER_INTERNAL_RC;
         3'h4: return SRC_SECONDARY_OSCILLATOR;
         3'h3, 3'h2: return SRC_PRI;
         default: return SRC_FRC;
      endcase
   endfunction
   // ********
   // properties
   // ********
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_grant;
      !waitrequest ##1 waitrequest;
   endsequence
   chk_wait_single: assert property ($rose(read || write) |=> s_grant)
      else $error("bus answer not a single cycle");
   chk_code_protect: assert property (
      ok |-> codeReadProtect == !r.codeProt)
      else $error("code protect wrong");
   chk_write_protect: assert property (
      ok |-> progWriteProtect == !r.writeProt)
      else $error("write protect wrong");
   chk_two_speed: assert property (
      ok |-> twoSpeedStartup == r.twoSpeed)
      else $error("two-speed flag wrong");
   chk_pwm_open: assert property (
      ok && !r.pwm_key_lock |-> pwmWriteEnable)
      else $error("pwm locked without lock field");
   chk_window_size: assert property (
      ok |-> watchdogWindowPermille == (r.watchdog_window_select == 2'h3 ? WIN_PM_24 :
         r.watchdog_window_select == 2'h2 ? WIN_PM_37_5 :
         r.watchdog_window_select == 2'h1 ? WIN_PM_50 : WIN_PM_75))
      else $error("window size wrong");
   chk_osc_source: assert property (
      ok |-> startupSource == src_of(r.oscSel)
         && pllEnable == (r.oscSel inside {3'h1, 3'h3})
         && oscSelectReserved == (r.oscSel == 3'h6))
      else $error("start-up source wrong");
   chk_clock_switch: assert property (
      ok |-> clockSwitchEnable == !r.clkSwMode[1]
         && failSafeMonitorEnable == (r.clkSwMode == 2'h0))
      else $error("clock switch mode wrong");
   chk_pin_clkout: assert property (
      ok |-> oscPinClockOut == (r.oscPinFn
         && !(r.primMode inside {2'h1, 2'h2})))
      else $error("oscillator pin function wrong");
   chk_primary_mode: assert property (
      ok |-> primaryOscModeOut == r.primMode
         && primaryOscEnable == (r.primMode != 2'h3))
      else $error("primary mode wrong");
   chk_wdt_forced: assert property (
      ok && r.wdtAlways |-> watchdogEnable && lowPowerRcEnable)
      else $error("watchdog not forced on");
   chk_window_mode: assert property (
      ok |-> watchdogWindowMode == !r.wdtWinDis)
      else $error("window mode wrong");
   chk_outputs_hold: assert property (
      ok |-> $stable({codeReadProtect, progWriteProtect, startupSource,
         primaryOscModeOut, watchdogWindowPermille, oscPinClockOut}))
      else $error("static output moved");
endmodule
bind config_word_decoder config_checker chk (.*);
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cfg_pkg::*;
   // arbitrary key words
   localparam logic [15:0] KEY1 = 16'h5a5a;
   localparam logic [15:0] KEY2 = 16'ha5a5;
   logic clk, arst_n, oscReady, pwmRegWrite, read, write, waitrequest;
   logic generalCodeProtect, generalWriteProtect, twoSpeedStartupEnable;
   logic pwmKeyLock, pinSelectOneShot, oscPinFunction, watchdogAlwaysOn;
   logic watchdogWindowDisable, configValid, codeReadProtect;
   logic progWriteProtect, twoSpeedStartup, pllEnable, oscSelectReserved;
   logic primaryOscEnable, clockSwitchEnable, failSafeMonitorEnable;
   logic pinRemapEnable, pwmWriteEnable, oscPinClockOut, watchdogEnable;
   logic lowPowerRcEnable, watchdogWindowMode;
   logic [1:0] watchdogWindowSelect, clockSwitchMonitorMode, primaryOscMode;
   logic [1:0] primaryOscModeOut;
   logic [2:0] startupOscillatorSelect, startupSource, activeSource;
   logic [7:0] address;
   logic [31:0] writedata, readdata;
   logic [3:0] byteenable;
   logic [9:0] watchdogWindowPermille;
   int err_total = 0;
   int num_checks = 0;
   logic [31:0] seed = 32'h00017a1e;
   cfg_raw_t f;
   cfg_raw_t nf;
   assign {generalCodeProtect, generalWriteProtect, twoSpeedStartupEnable,
      pwmKeyLock, watchdogWindowSelect, startupOscillatorSelect,
      clockSwitchMonitorMode, pinSelectOneShot, oscPinFunction,
      primaryOscMode, watchdogAlwaysOn, watchdogWindowDisable} = f;
   config_word_decoder #(.ADDR_W(8), .PWM_KEY_FIRST(KEY1),
      .PWM_KEY_SECOND(KEY2)) DUT (.*);
   // ********
   // helpers
   // ********
   // 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [2:0] exp_src(input logic [2:0] s);
      case (s)
         3'h7, 3'h1: return SRC_FRCDIV;
         3'h5: return SRC_LOW_POWER_INTERNAL_RC;
         3'h4: return SRC_SECONDARY_OSCILLATOR;
         3'h3, 3'h2: return SRC_PRI;
         default: return SRC_FRC;
      endcase
   endfunction
   task automatic check(input string what, input logic [31:0] got,
         input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // request held till waitrequest is low
   task automatic bus(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n = 0;
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 40);
      q = readdata;
      check("bus answer", n < 40, 1'b1);
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // hang guard, far beyond the expected run
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim();
   end
   // ********
   // scenarios
   // ********
   initial begin
      logic [31:0] q;
      int n;
      arst_n = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 8'h00;
      writedata = 32'h0;
      byteenable = 4'hf;
      oscReady = 1'b0;
      pwmRegWrite = 1'b0;
      f = '0;
      for (int i = 0; i < 14; i++) begin
         q = rnd();
         nf = q[16:0];
         nf.oscSel = (i % 7 == 6) ? 3'h7 : 3'(i % 7); // not reserved
         nf.watchdog_window_select = i[1:0];
         nf.clkSwMode = i[2:1];
         nf.primMode = i[3:2];
         f <= nf;
         oscReady <= 1'b0;
         arst_n <= 1'b0;
         repeat (10) @(posedge clk);
         arst_n <= 1'b1;
         repeat (8) @(posedge clk);
         check("protect", {configValid, codeReadProtect, progWriteProtect},
            {1'b1, !nf.codeProt, !nf.writeProt});
         check("source", startupSource, exp_src(nf.oscSel));
         check("active", activeSource,
            nf.twoSpeed ? SRC_FRC : exp_src(nf.oscSel));
         // target ready ends the fast rc phase
         oscReady <= 1'b1;
         n = 0;
         while (activeSource !== exp_src(nf.oscSel) && n < 20) begin
            @(posedge clk);
            n++;
         end
         check("switched", activeSource, exp_src(nf.oscSel));
         bus(1'b0, OFS_SAMPLED, 32'h0, q);
         check("sampled", q, {15'h0, nf});
         bus(1'b0, 8'h40, 32'h0, q);
         check("unmapped", q, 32'h0);
         // software enable is ignored while always-on is set
         bus(1'b1, OFS_WDT_CTRL, 32'h1, q);
         check("wdt on", {watchdogEnable, lowPowerRcEnable}, 2'h3);
         bus(1'b1, OFS_WDT_CTRL, 32'h0, q);
         check("wdt off", watchdogEnable, nf.wdtAlways);
         bus(1'b0, OFS_WDT_CTRL, 32'h0, q);
         check("wdt reg", q[1:0], {nf.wdtAlways, 1'b0});
         // a wrong second word must not unlock
         check("pwm idle", pwmWriteEnable, !nf.pwm_key_lock);
         bus(1'b1, OFS_PWM_KEY, 32'(KEY1), q);
         bus(1'b1, OFS_PWM_KEY, 32'(KEY1), q);
         check("pwm bad key", pwmWriteEnable, !nf.pwm_key_lock);
         bus(1'b1, OFS_PWM_KEY, 32'(KEY1), q);
         bus(1'b1, OFS_PWM_KEY, 32'(KEY2), q);
         check("pwm key", pwmWriteEnable, 1'b1);
         pwmRegWrite <= 1'b1;
         @(posedge clk);
         pwmRegWrite <= 1'b0;
         repeat (3) @(posedge clk);
         check("pwm relock", pwmWriteEnable, !nf.pwm_key_lock);
         // second commit is refused only with the one-shot field set
         bus(1'b1, OFS_REMAP, 32'h1, q);
         bus(1'b1, OFS_REMAP, 32'h1, q);
         bus(1'b0, OFS_REMAP, 32'h0, q);
         check("remap", q[2:0], {3{nf.pinOneShot}});
         check("remap pin", pinRemapEnable, !nf.pinOneShot);
         // every field but the oscillator code flips after capture
         f <= nf ^ 17'h1f8ff;
         repeat (4) @(posedge clk);
         check("hold", {codeReadProtect, startupSource, primaryOscModeOut,
            watchdogWindowMode}, {~nf.codeProt, exp_src(nf.oscSel),
            nf.primMode, ~nf.wdtWinDis});
         bus(1'b0, OFS_SAMPLED, 32'h0, q);
         check("sampled hold", q, {15'h0, nf});
      end
      end_sim();
   end
endmodule
`default_nettype wire
